/* csw_pkg.sv */
// ============================================================
// Shared constants and types of the clock switch block.
package csw_pkg;

    // ============================================================
    // Register offsets and field positions.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_KEY = 8'h04;
    localparam int CUR_MSB = 14;
    localparam int CUR_LSB = 12;
    localparam int NEXT_MSB = 10;
    localparam int NEXT_LSB = 8;
    localparam int BIT_LOCK = 5;
    localparam int BIT_CF = 3;
    localparam int BIT_KEEP = 1;
    localparam int BIT_REQ = 0;

    // ============================================================
    // Unlock keys; the values are arbitrary.
    localparam logic [31:0] KEY_HI_1 = 32'h0000_00A5;
    localparam logic [31:0] KEY_HI_2 = 32'h0000_005A;
    localparam logic [31:0] KEY_LO_1 = 32'h0000_003C;
    localparam logic [31:0] KEY_LO_2 = 32'h0000_00C3;

    // ============================================================
    // Source codes, oscillator indices and submodes.
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_LP = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
    localparam logic [1:0] OSC_FRC = 2'h0;
    localparam logic [1:0] OSC_PRI = 2'h1;
    localparam logic [1:0] OSC_LP = 2'h2;
    localparam logic [1:0] OSC_LOW_POWER_INTERNAL_RC = 2'h3;
    localparam logic [1:0] SUB_EXT_CLOCK = 2'h0;
    localparam logic [3:0] GATE_RESET = 4'h1;
    localparam logic [3:0] SETTLE_CYCLES = 4'hA;
    localparam logic [1:0] GATE_GAP_CYCLES = 2'h2;

    typedef enum logic [2:0] {CSW_IDLE, CSW_WAIT_RDY, CSW_COUNT, CSW_SWITCH, CSW_FAILOVER} csw_state_t;
    typedef enum logic [1:0] {KEY_LOCKED, KEY_HI_HALF, KEY_LO_HALF} csw_key_t;
    typedef enum logic [1:0] {GATE_IDLE, GATE_GAP} csw_gate_t;

    // Codes 6 and 7 are unused and fall back to the fast RC oscillator.
    function automatic logic [1:0] src_phys(input logic [2:0] src);
        logic [1:0] p;
        p = OSC_FRC;
        if (src == SRC_PRI || src == SRC_PRI_PLL) begin
            p = OSC_PRI;
        end else if (src == SRC_LP) begin
            p = OSC_LP;
        end else if (src == SRC_LOW_POWER_INTERNAL_RC) begin
            p = OSC_LOW_POWER_INTERNAL_RC;
        end
        return p;
    endfunction

    function automatic logic src_pll(input logic [2:0] src);
        return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
    endfunction

    function automatic logic [3:0] osc_onehot(input logic [1:0] p);
        return 4'h1 << p;
    endfunction

endpackage

/* csw_unlock.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Key sequencer: a pair of key writes opens one control byte.
module csw_unlock (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic key_write,
    input wire logic [31:0] key_data,
    input wire logic ctrl_write,
    output logic hi_open,
    output logic lo_open
);
    typedef struct packed {
        csw_pkg::csw_key_t ks;
        logic hi_open;
        logic lo_open;
    } csw_unlock_state_t;

    csw_unlock_state_t s_reg;
    csw_unlock_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (ctrl_write) begin
            s_next.hi_open = 1'b0;
            s_next.lo_open = 1'b0;
        end
        if (key_write) begin
            // A new key write always withdraws any earlier opening.
            s_next.hi_open = 1'b0;
            s_next.lo_open = 1'b0;
            s_next.ks = csw_pkg::KEY_LOCKED;
            case (s_reg.ks)
                csw_pkg::KEY_LOCKED: begin
                    if (key_data == csw_pkg::KEY_HI_1) begin
                        s_next.ks = csw_pkg::KEY_HI_HALF;
                    end else if (key_data == csw_pkg::KEY_LO_1) begin
                        s_next.ks = csw_pkg::KEY_LO_HALF;
                    end
                end
                csw_pkg::KEY_HI_HALF: begin
                    s_next.hi_open = (key_data == csw_pkg::KEY_HI_2);
                end
                default: begin
                    s_next.lo_open = (key_data == csw_pkg::KEY_LO_2);
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{ks: csw_pkg::KEY_LOCKED, hi_open: 1'b0, lo_open: 1'b0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign hi_open = s_reg.hi_open;
    assign lo_open = s_reg.lo_open;
endmodule
`default_nettype wire

/* csw_clk_gate.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Break-before-make sequencer for the system clock gates.
module csw_clk_gate (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic switch_req,
    input wire logic [1:0] switch_target,
    output logic [3:0] gate,
    output logic busy,
    output logic done
);
    typedef struct packed {
        csw_pkg::csw_gate_t gs;
        logic [3:0] gate;
        logic [1:0] tgt;
        logic [1:0] cnt;
        logic busy;
        logic done;
    } csw_gate_state_t;

    csw_gate_state_t s_reg;
    csw_gate_state_t s_next;

    // All gates stay closed for a gap so that neither clock can leave
    // a shortened pulse on the system clock.
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (switch_req) begin
            s_next.gate = 4'h0;
            s_next.tgt = switch_target;
            s_next.cnt = 2'h0;
            s_next.busy = 1'b1;
            s_next.gs = csw_pkg::GATE_GAP;
        end else if (s_reg.gs == csw_pkg::GATE_GAP) begin
            if (s_reg.cnt == csw_pkg::GATE_GAP_CYCLES - 2'h1) begin
                s_next.gate = csw_pkg::osc_onehot(s_reg.tgt);
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.gs = csw_pkg::GATE_IDLE;
            end else begin
                s_next.cnt = s_reg.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{gs: csw_pkg::GATE_IDLE, gate: csw_pkg::GATE_RESET, tgt: csw_pkg::OSC_FRC,
                       cnt: 2'h0, busy: 1'b0, done: 1'b0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign gate = s_reg.gate;
    assign busy = s_reg.busy;
    assign done = s_reg.done;

    gate_onehot_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $onehot0(s_reg.gate)) else $error("More than one clock gate open.");
endmodule
`default_nettype wire

/* csw_top.sv */
`timescale 1ns/10ps
`default_nettype none
module csw_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic clk_switch_disable_cfg,
    input wire logic fail_safe_disable_cfg,
    input wire logic [2:0] initial_osc_cfg,
    input wire logic [1:0] primary_osc_submode_cfg,
    input wire logic watchdog_enable_cfg,
    input wire logic sleep_mode,
    input wire logic osc_startup_timer_done,
    input wire logic pll_lock_in,
    input wire logic [3:0] new_clk_tick,
    input wire logic osc_fail_detect,
    output logic [3:0] osc_enable,
    output logic pll_enable,
    output logic [1:0] primary_osc_submode,
    output logic [3:0] sys_clk_gate,
    output logic [2:0] current_osc_sel,
    output logic clock_fail_trap,
    output logic switch_busy
);
    // ============================================================
    // State.
    typedef struct packed {
        csw_pkg::csw_state_t st;
        logic booted;
        logic [2:0] cur;
        logic [2:0] nxt;
        logic [2:0] tgt;
        logic req;
        logic lock;
        logic cf;
        logic keep;
        logic ost_wait;
        logic [3:0] cnt;
        logic [3:0] osc_en;
        logic pll_en;
        logic [1:0] submode;
        logic trap;
        logic mux_req;
        logic [1:0] mux_tgt;
        logic dp_wr;
        logic dp_ctrl;
        logic dp_key;
        logic [31:0] hrdata;
        logic hreadyout;
        logic busy;
    } csw_top_state_t;

    csw_top_state_t s_reg;
    csw_top_state_t s_next;
    logic hi_open;
    logic lo_open;
    logic gate_busy;
    logic gate_done;
    logic [3:0] gate;
    logic sw_en;
    logic fail_safe_monitor_en;
    logic [1:0] tgt_phys;

    // The switch disable bit enables switching at zero; the fail-safe monitor needs both disable bits at zero.
    assign sw_en = !clk_switch_disable_cfg;
    assign fail_safe_monitor_en = sw_en && !fail_safe_disable_cfg;
    assign tgt_phys = csw_pkg::src_phys(s_reg.tgt);

    csw_unlock u_unlock (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .key_write(s_reg.dp_wr && s_reg.dp_key),
        .key_data(hwdata),
        .ctrl_write(s_reg.dp_wr && s_reg.dp_ctrl),
        .hi_open(hi_open),
        .lo_open(lo_open)
    );

    csw_clk_gate u_clk_gate (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .switch_req(s_reg.mux_req),
        .switch_target(s_reg.mux_tgt),
        .gate(gate),
        .busy(gate_busy),
        .done(gate_done)
    );

    // ============================================================
    // Next state.
    always_comb begin
        logic [31:0] rd;
        logic addr_ok;
        logic ready;
        logic low_power_internal_rc_hold;
        rd = 32'h0000_0000;
        addr_ok = hsel && htrans[1] && hready;
        ready = 1'b0;
        low_power_internal_rc_hold = 1'b0;
        s_next = s_reg;
        s_next.trap = 1'b0;
        s_next.mux_req = 1'b0;
        s_next.hreadyout = 1'b1;
        s_next.submode = primary_osc_submode_cfg;
        s_next.dp_wr = addr_ok && hwrite;
        s_next.dp_ctrl = haddr[7:0] == csw_pkg::OFS_CTRL;
        s_next.dp_key = haddr[7:0] == csw_pkg::OFS_KEY;
        rd[csw_pkg::CUR_MSB:csw_pkg::CUR_LSB] = s_reg.cur;
        rd[csw_pkg::NEXT_MSB:csw_pkg::NEXT_LSB] = s_reg.nxt;
        rd[csw_pkg::BIT_LOCK] = s_reg.lock;
        rd[csw_pkg::BIT_CF] = s_reg.cf;
        rd[csw_pkg::BIT_KEEP] = s_reg.keep;
        rd[csw_pkg::BIT_REQ] = s_reg.req && sw_en;
        if (addr_ok && !hwrite) begin
            s_next.hrdata = s_next.dp_ctrl ? rd : 32'h0000_0000;
        end
        if (!s_reg.booted || !sw_en) begin
            // The strap is sampled after reset and then tracked while switching is off.
            s_next.booted = 1'b1;
            s_next.cur = initial_osc_cfg;
            s_next.tgt = initial_osc_cfg;
            s_next.req = 1'b0;
            s_next.st = csw_pkg::CSW_IDLE;
            s_next.osc_en = csw_pkg::osc_onehot(csw_pkg::src_phys(initial_osc_cfg));
            s_next.pll_en = csw_pkg::src_pll(initial_osc_cfg);
            if (!gate_busy && !s_reg.mux_req && gate != s_next.osc_en) begin
                s_next.mux_req = 1'b1;
                s_next.mux_tgt = csw_pkg::src_phys(initial_osc_cfg);
            end
        end else begin
            if (s_reg.dp_wr && s_reg.dp_ctrl) begin
                if (hi_open) begin
                    s_next.nxt = hwdata[csw_pkg::NEXT_MSB:csw_pkg::NEXT_LSB];
                end
                if (lo_open) begin
                    s_next.keep = hwdata[csw_pkg::BIT_KEEP];
                    s_next.req = s_reg.req || hwdata[csw_pkg::BIT_REQ];
                    s_next.cf = s_reg.cf && hwdata[csw_pkg::BIT_CF];
                end
            end
            case (s_reg.st)
                csw_pkg::CSW_IDLE: begin
                    if (s_reg.req) begin
                        if (s_reg.nxt == s_reg.cur) begin
                            s_next.req = 1'b0;
                        end else begin
                            s_next.cf = 1'b0;
                            s_next.lock = 1'b0;
                            s_next.tgt = s_reg.nxt;
                            s_next.ost_wait = !s_reg.osc_en[csw_pkg::src_phys(s_reg.nxt)] &&
                                ((csw_pkg::src_phys(s_reg.nxt) == csw_pkg::OSC_PRI &&
                                  s_reg.submode != csw_pkg::SUB_EXT_CLOCK) ||
                                 csw_pkg::src_phys(s_reg.nxt) == csw_pkg::OSC_LP);
                            s_next.osc_en[csw_pkg::src_phys(s_reg.nxt)] = 1'b1;
                            s_next.pll_en = s_reg.pll_en || csw_pkg::src_pll(s_reg.nxt);
                            s_next.st = csw_pkg::CSW_WAIT_RDY;
                        end
                    end
                end
                csw_pkg::CSW_WAIT_RDY: begin
                    ready = (!s_reg.ost_wait || osc_startup_timer_done) &&
                        (!csw_pkg::src_pll(s_reg.tgt) || pll_lock_in);
                    if (ready) begin
                        s_next.cnt = 4'h0;
                        s_next.st = csw_pkg::CSW_COUNT;
                    end
                end
                csw_pkg::CSW_COUNT: begin
                    if (new_clk_tick[tgt_phys]) begin
                        if (s_reg.cnt == csw_pkg::SETTLE_CYCLES - 4'h1) begin
                            s_next.mux_req = 1'b1;
                            s_next.mux_tgt = tgt_phys;
                            s_next.st = csw_pkg::CSW_SWITCH;
                        end else begin
                            s_next.cnt = s_reg.cnt + 4'h1;
                        end
                    end
                end
                csw_pkg::CSW_SWITCH: begin
                    if (gate_done) begin
                        s_next.cur = s_reg.tgt;
                        s_next.req = 1'b0;
                        s_next.osc_en = csw_pkg::osc_onehot(tgt_phys);
                        s_next.osc_en[csw_pkg::OSC_LP] = s_next.osc_en[csw_pkg::OSC_LP] || s_reg.keep;
                        s_next.pll_en = csw_pkg::src_pll(s_reg.tgt);
                        s_next.st = csw_pkg::CSW_IDLE;
                    end
                end
                default: begin
                    if (gate_done) begin
                        s_next.st = csw_pkg::CSW_IDLE;
                    end
                end
            endcase
            if (s_reg.pll_en && pll_lock_in) begin
                s_next.lock = 1'b1;
            end
            // A failure in the cycle of a status clear still sets the flag.
            if (fail_safe_monitor_en && osc_fail_detect && s_reg.st != csw_pkg::CSW_FAILOVER) begin
                s_next.trap = 1'b1;
                s_next.cf = 1'b1;
                s_next.cur = s_reg.pll_en ? csw_pkg::SRC_FRC_PLL : csw_pkg::SRC_FRC;
                s_next.tgt = s_next.cur;
                s_next.req = 1'b0;
                s_next.pll_en = s_reg.pll_en;
                s_next.osc_en[csw_pkg::OSC_FRC] = 1'b1;
                s_next.mux_req = 1'b1;
                s_next.mux_tgt = csw_pkg::OSC_FRC;
                s_next.st = csw_pkg::CSW_FAILOVER;
            end
        end
        low_power_internal_rc_hold = (fail_safe_monitor_en && !sleep_mode) || (!fail_safe_monitor_en && watchdog_enable_cfg) ||
            csw_pkg::src_phys(s_next.cur) == csw_pkg::OSC_LOW_POWER_INTERNAL_RC ||
            (csw_pkg::src_phys(s_next.tgt) == csw_pkg::OSC_LOW_POWER_INTERNAL_RC);
        s_next.osc_en[csw_pkg::OSC_LOW_POWER_INTERNAL_RC] = low_power_internal_rc_hold;
        s_next.busy = s_next.st != csw_pkg::CSW_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '{st: csw_pkg::CSW_IDLE, booted: 1'b0, cur: csw_pkg::SRC_FRC, nxt: csw_pkg::SRC_FRC,
                       tgt: csw_pkg::SRC_FRC, req: 1'b0, lock: 1'b0, cf: 1'b0, keep: 1'b0, ost_wait: 1'b0,
                       cnt: 4'h0, osc_en: csw_pkg::GATE_RESET, pll_en: 1'b0, submode: csw_pkg::SUB_EXT_CLOCK,
                       trap: 1'b0, mux_req: 1'b0, mux_tgt: csw_pkg::OSC_FRC, dp_wr: 1'b0, dp_ctrl: 1'b0,
                       dp_key: 1'b0, hrdata: 32'h0000_0000, hreadyout: 1'b1, busy: 1'b0};
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // Outputs.
    assign hreadyout = s_reg.hreadyout;
    assign hrdata = s_reg.hrdata;
    assign hresp = 1'b0;
    assign osc_enable = s_reg.osc_en;
    assign pll_enable = s_reg.pll_en;
    assign primary_osc_submode = s_reg.submode;
    assign sys_clk_gate = gate;
    assign current_osc_sel = s_reg.cur;
    assign clock_fail_trap = s_reg.trap;
    assign switch_busy = s_reg.busy;

    // ============================================================
    // Checks.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    req_reads_zero_a: assert property (!sw_en && s_reg.booted |-> !s_reg.req)
        else $error("Switch request set while switching is disabled.");
    cur_follows_cfg_a: assert property (clk_en && !sw_en |=> s_reg.cur == $past(initial_osc_cfg))
        else $error("Current source does not follow the initial configuration.");
    redundant_abort_a: assert property (clk_en && sw_en && s_reg.booted && s_reg.st == csw_pkg::CSW_IDLE &&
        s_reg.req && s_reg.nxt == s_reg.cur && !osc_fail_detect && !(s_reg.dp_wr && lo_open)
        |=> !s_reg.req && s_reg.st == csw_pkg::CSW_IDLE)
        else $error("Redundant request was not aborted.");
    start_clears_cf_a: assert property (clk_en && sw_en && s_reg.booted && s_reg.st == csw_pkg::CSW_IDLE &&
        s_reg.req && s_reg.nxt != s_reg.cur && !osc_fail_detect |=> !s_reg.cf && s_reg.st == csw_pkg::CSW_WAIT_RDY)
        else $error("Valid switch did not clear the fail flag.");
    pll_wait_a: assert property (clk_en && sw_en && s_reg.st == csw_pkg::CSW_WAIT_RDY &&
        csw_pkg::src_pll(s_reg.tgt) && !pll_lock_in && !osc_fail_detect |=> s_reg.st == csw_pkg::CSW_WAIT_RDY)
        else $error("Switch went on without PLL lock.");
    count_ten_a: assert property (clk_en && sw_en && s_reg.st == csw_pkg::CSW_COUNT &&
        s_reg.cnt == csw_pkg::SETTLE_CYCLES - 4'h1 && new_clk_tick[tgt_phys] && !osc_fail_detect
        |=> s_reg.st == csw_pkg::CSW_SWITCH && s_reg.mux_req)
        else $error("Settle count did not end the wait.");
    switch_done_a: assert property (clk_en && sw_en && s_reg.st == csw_pkg::CSW_SWITCH && gate_done &&
        !osc_fail_detect |=> s_reg.cur == $past(s_reg.tgt) && !s_reg.req && s_reg.st == csw_pkg::CSW_IDLE)
        else $error("Completion did not update the current source.");
    fail_trap_a: assert property (clk_en && fail_safe_monitor_en && s_reg.booted && osc_fail_detect &&
        s_reg.st != csw_pkg::CSW_FAILOVER |=> clock_fail_trap && s_reg.cf ##1 !clock_fail_trap)
        else $error("Failure did not raise a one-cycle trap.");
    fail_keeps_pll_a: assert property (clk_en && fail_safe_monitor_en && s_reg.booted && osc_fail_detect &&
        s_reg.pll_en && s_reg.st != csw_pkg::CSW_FAILOVER |=> s_reg.cur == csw_pkg::SRC_FRC_PLL && s_reg.pll_en)
        else $error("Fallback lost the PLL.");
    low_power_internal_rc_runs_a: assert property (clk_en && fail_safe_monitor_en && !sleep_mode |=> s_reg.osc_en[csw_pkg::OSC_LOW_POWER_INTERNAL_RC])
        else $error("Low-power RC stopped while the monitor is on.");

    switch_seen_c: cover property (s_reg.st == csw_pkg::CSW_SWITCH && gate_done);
    redundant_seen_c: cover property (s_reg.st == csw_pkg::CSW_IDLE && s_reg.req && s_reg.nxt == s_reg.cur && sw_en);
    failover_seen_c: cover property (clock_fail_trap);
endmodule
`default_nettype wire

/* csw_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Oscillators and PLL; ticks come every other cycle, a slow far side.
module csw_osc_model (
    input wire logic hclk,
    input wire logic [3:0] osc_enable,
    input wire logic pll_enable,
    output logic [3:0] new_clk_tick,
    output logic osc_startup_timer_done,
    output logic pll_lock_in
);
    logic ph = 1'b0;
    logic [3:0] osc_startup_timer = 4'h0;
    logic [2:0] pll = 3'h0;
    always @(posedge hclk) begin
        ph <= ~ph;
        osc_startup_timer <= (osc_enable[1] | osc_enable[2]) ? ((osc_startup_timer == 4'h8) ? osc_startup_timer : osc_startup_timer + 4'h1) : 4'h0;
        pll <= pll_enable ? ((pll == 3'h6) ? pll : pll + 3'h1) : 3'h0;
    end
    assign new_clk_tick = ph ? osc_enable : 4'h0;
    assign osc_startup_timer_done = (osc_startup_timer == 4'h8);
    assign pll_lock_in = (pll == 3'h6);
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, osc_startup_timer, lock, trap, busy, pe;
    logic dis = 1'b1, fail = 1'b0, slp = 1'b0;
    logic [1:0] htrans = 2'h0, sub;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [3:0] tick, oen, gate;
    logic [2:0] cur, init = 3'h0;
    int errors = 0, checked = 0;
    always #5 hclk = ~hclk;
    csw_top csw_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(hresp), .clk_switch_disable_cfg(dis), .fail_safe_disable_cfg(1'b0),
        .initial_osc_cfg(init), .primary_osc_submode_cfg(2'h1), .watchdog_enable_cfg(1'b0), .sleep_mode(slp),
        .osc_startup_timer_done(osc_startup_timer), .pll_lock_in(lock), .new_clk_tick(tick), .osc_fail_detect(fail),
        .osc_enable(oen), .pll_enable(pe), .primary_osc_submode(sub), .sys_clk_gate(gate),
        .current_osc_sel(cur), .clock_fail_trap(trap), .switch_busy(busy));
    csw_osc_model csw_osc_model_inst (.hclk(hclk), .osc_enable(oen), .pll_enable(pe), .new_clk_tick(tick),
        .osc_startup_timer_done(osc_startup_timer), .pll_lock_in(lock));
    // ============================================================
    // Bus and check helpers.
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        chk("bus answer", {hready, hresp}, 2'h2);
    endtask
    task rst(input logic d, input logic [2:0] i);
        dis <= d;
        init <= i;
        hresetn <= 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    task sw(input logic [2:0] s);
        ahb(1'b1, csw_pkg::OFS_KEY, csw_pkg::KEY_HI_1);
        ahb(1'b1, csw_pkg::OFS_KEY, csw_pkg::KEY_HI_2);
        ahb(1'b1, csw_pkg::OFS_CTRL, {21'h0, s, 8'h00});
        ahb(1'b1, csw_pkg::OFS_KEY, csw_pkg::KEY_LO_1);
        ahb(1'b1, csw_pkg::OFS_KEY, csw_pkg::KEY_LO_2);
        ahb(1'b1, csw_pkg::OFS_CTRL, {21'h0, s, 8'h09});
        repeat (3) @(posedge hclk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge hclk);
        ahb(1'b0, csw_pkg::OFS_CTRL, 32'h0);
    endtask
    task results;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ============================================================
    // Scenarios.
    initial begin
        rst(1'b1, csw_pkg::SRC_PRI);
        sw(csw_pkg::SRC_PRI_PLL);
        chk("off request", r[0], 1'b0);
        chk("off current", {r[14:12], cur}, {csw_pkg::SRC_PRI, csw_pkg::SRC_PRI});
        chk("off gate", {gate, oen}, 8'h22);
        rst(1'b0, csw_pkg::SRC_FRC);
        sw(csw_pkg::SRC_PRI);
        chk("pri current", {r[14:12], r[0], cur}, {csw_pkg::SRC_PRI, 1'b0, csw_pkg::SRC_PRI});
        chk("pri gate", {gate, oen}, 8'h2A);
        chk("submode", sub, 2'h1);
        @(posedge hclk);
        slp <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("sleep low_power_internal_rc", oen, 4'h2);
        slp <= 1'b0;
        sw(csw_pkg::SRC_PRI);
        chk("redundant", {r[14:12], r[0]}, {csw_pkg::SRC_PRI, 1'b0});
        sw(csw_pkg::SRC_PRI_PLL);
        chk("pll lock", {r[14:12], r[5], r[3], pe}, {csw_pkg::SRC_PRI_PLL, 3'h5});
        @(posedge hclk);
        fail <= 1'b1;
        @(posedge hclk);
        fail <= 1'b0;
        #1;
        chk("trap", trap, 1'b1);
        sw(csw_pkg::SRC_FRC_PLL);
        chk("fallback", {r[14:12], r[3], cur, gate[0]},
            {csw_pkg::SRC_FRC_PLL, 1'b1, csw_pkg::SRC_FRC_PLL, 1'b1});
        sw(csw_pkg::SRC_FRC);
        chk("frc return", {r[14:12], r[3], pe, oen}, {csw_pkg::SRC_FRC, 2'h0, 4'h9});
        results();
    end
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule
`default_nettype wire
